// File: verilog/tws_scheduler.sv
// Purpose: weighted round-robin choice among 16 transmit descriptor queues
// Assumes: queue pending flags and done strobe come from logic on I_CLK
// Notes: registers reached over a plain strobe port, read data one cycle later
//
// The placing of the registers and the strobed register port are this design's own decisions.

// How it works
// - any queue select value 0 to 15 steers service to that queue
// - burst field value n means n plus one contiguous messages
// - entry five: word one bits 11-8 queue, 15-12 burst; then six
// - entry six: word one bits 19-16 queue, 23-20 burst; then seven
// - entry seven: word one bits 27-24 queue, 31-28 burst; then eight
// - entry eight: word two bits 3-0 queue, 7-4 burst; then nine
// - entry nine: word two bits 11-8 queue, 15-12 burst; then ten
// - entry ten: word two bits 19-16 queue, 23-20 burst; then eleven
// - entry eleven: word two bits 27-24 queue, 31-28 burst; then twelve
// - entry twelve: word three bits 3-0 queue, 7-4 burst; then thirteen
// - entry thirteen: word three bits 11-8 queue, 15-12 burst; then fourteen
// - entry fourteen: word three bits 19-16 queue, 23-20 burst; then fifteen
// - after entry fifteen the ring wraps to entry zero
module tws_scheduler (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // queue side
    input wire logic [15:0] I_QUEUE_PENDING,
    input wire logic I_DESC_DONE,
    output logic O_GRANT_VALID,
    output logic [3:0] O_GRANT_QUEUE,
    output logic [3:0] O_ENTRY,
    output logic [3:0] O_MSG_COUNT
);

    tws_pkg::tws_map_s map;
    logic enable;
    tws_pkg::tws_state_e state;
    tws_pkg::tws_state_e next_state;
    logic [3:0] cur_entry;
    logic [3:0] cur_queue;
    logic [3:0] cur_burst;
    logic [3:0] count;
    logic [3:0] next_entry;
    tws_pkg::tws_entry_s next_ent;
    logic serving;
    logic skip;
    logic burst_end;
    logic advance;
    logic took;
    logic [31:0] status_word;

    // register writes
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            map.zero <= tws_pkg::RST_MAP_ZERO;
            map.one <= tws_pkg::RST_MAP_ONE;
            map.two <= tws_pkg::RST_MAP_TWO;
            map.three <= tws_pkg::RST_MAP_THREE;
            enable <= tws_pkg::RST_ENABLE;
        end else if (I_WR) begin
            case (I_ADDR)
                tws_pkg::OFS_MAP_ZERO: map.zero <= I_WDATA;
                tws_pkg::OFS_MAP_ONE: map.one <= I_WDATA;
                tws_pkg::OFS_MAP_TWO: map.two <= I_WDATA;
                tws_pkg::OFS_MAP_THREE: map.three <= I_WDATA;
                tws_pkg::OFS_CTRL: enable <= I_WDATA[tws_pkg::CTRL_ENABLE_BIT];
                default: enable <= enable;
            endcase
        end
    end

    // status word
    always_comb begin
        status_word = '0;
        status_word[tws_pkg::STAT_ENTRY_LSB +: 4] = cur_entry;
        status_word[tws_pkg::STAT_COUNT_LSB +: 4] = count;
        status_word[tws_pkg::STAT_QUEUE_LSB +: 4] = cur_queue;
        status_word[tws_pkg::STAT_BURST_LSB +: 4] = cur_burst;
        status_word[tws_pkg::STAT_BUSY_BIT] = serving;
    end

    // register reads, data in the following cycle only
    always_ff @(posedge I_CLK) begin
        if (I_RST || !I_RD) begin
            O_RDATA <= '0;
        end else begin
            case (I_ADDR)
                tws_pkg::OFS_MAP_ZERO: O_RDATA <= map.zero;
                tws_pkg::OFS_MAP_ONE: O_RDATA <= map.one;
                tws_pkg::OFS_MAP_TWO: O_RDATA <= map.two;
                tws_pkg::OFS_MAP_THREE: O_RDATA <= map.three;
                tws_pkg::OFS_CTRL: O_RDATA <= {31'h00000000, enable};
                tws_pkg::OFS_STATUS: O_RDATA <= status_word;
                default: O_RDATA <= '0;
            endcase
        end
    end

    // advance decision
    always_comb begin
        serving = (state == tws_pkg::ST_SERVE);
        skip = serving && !I_QUEUE_PENDING[cur_queue];
        took = serving && I_QUEUE_PENDING[cur_queue] && I_DESC_DONE;
        burst_end = took && (count == cur_burst);
        advance = skip || burst_end;
        next_entry = advance ? tws_pkg::ring_next(cur_entry) : cur_entry;
        next_state = enable ? tws_pkg::ST_SERVE : tws_pkg::ST_IDLE;
    end

    // field lookup for the entry about to be current
    tws_entry_decode u_decode (
        .i_map(map),
        .i_entry(next_entry),
        .o_entry(next_ent)
    );

    // state
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state <= tws_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ring position and its fields, refreshed every cycle
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            cur_entry <= 4'h0;
            cur_queue <= 4'h0;
            cur_burst <= 4'h0;
        end else begin
            cur_entry <= next_entry;
            cur_queue <= next_ent.queue;
            cur_burst <= next_ent.burst;
        end
    end

    // messages taken within the current burst
    always_ff @(posedge I_CLK) begin
        if (I_RST || advance || !serving) begin
            count <= 4'h0;
        end else if (took) begin
            count <= 4'(count + 4'h1);
        end
    end

    // registered outputs
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_GRANT_VALID <= 1'b0;
            O_GRANT_QUEUE <= 4'h0;
            O_ENTRY <= 4'h0;
            O_MSG_COUNT <= 4'h0;
        end else begin
            O_GRANT_VALID <= (next_state == tws_pkg::ST_SERVE);
            O_GRANT_QUEUE <= next_ent.queue;
            O_ENTRY <= next_entry;
            O_MSG_COUNT <= (advance || !serving) ? 4'h0 : (took ? 4'(count + 4'h1) : count);
        end
    end

    // checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    entry_five_map_a: assert property ($stable(map) && cur_entry == 4'h5 |->
        cur_queue == map.one[11:8] && cur_burst == map.one[15:12])
        else $error("entry five fields wrong");
    entry_six_map_a: assert property ($stable(map) && cur_entry == 4'h6 |->
        cur_queue == map.one[19:16] && cur_burst == map.one[23:20])
        else $error("entry six fields wrong");
    entry_seven_map_a: assert property ($stable(map) && cur_entry == 4'h7 |->
        cur_queue == map.one[27:24] && cur_burst == map.one[31:28])
        else $error("entry seven fields wrong");
    entry_eight_map_a: assert property ($stable(map) && cur_entry == 4'h8 |->
        cur_queue == map.two[3:0] && cur_burst == map.two[7:4])
        else $error("entry eight fields wrong");
    entry_nine_map_a: assert property ($stable(map) && cur_entry == 4'h9 |->
        cur_queue == map.two[11:8] && cur_burst == map.two[15:12])
        else $error("entry nine fields wrong");
    entry_ten_map_a: assert property ($stable(map) && cur_entry == 4'hA |->
        cur_queue == map.two[19:16] && cur_burst == map.two[23:20])
        else $error("entry ten fields wrong");
    entry_eleven_map_a: assert property ($stable(map) && cur_entry == 4'hB |->
        cur_queue == map.two[27:24] && cur_burst == map.two[31:28])
        else $error("entry eleven fields wrong");
    entry_twelve_map_a: assert property ($stable(map) && cur_entry == 4'hC |->
        cur_queue == map.three[3:0] && cur_burst == map.three[7:4])
        else $error("entry twelve fields wrong");
    entry_thirteen_map_a: assert property ($stable(map) && cur_entry == 4'hD |->
        cur_queue == map.three[11:8] && cur_burst == map.three[15:12])
        else $error("entry thirteen fields wrong");
    entry_fourteen_map_a: assert property ($stable(map) && cur_entry == 4'hE |->
        cur_queue == map.three[19:16] && cur_burst == map.three[23:20])
        else $error("entry fourteen fields wrong");

    burst_hold_a: assert property (O_GRANT_VALID && I_QUEUE_PENDING[O_GRANT_QUEUE] && I_DESC_DONE &&
        O_MSG_COUNT != cur_burst |=> O_ENTRY == $past(O_ENTRY) && O_MSG_COUNT == 4'($past(O_MSG_COUNT) + 4'h1))
        else $error("burst ended early");
    burst_end_a: assert property (O_GRANT_VALID && I_QUEUE_PENDING[O_GRANT_QUEUE] && I_DESC_DONE &&
        O_MSG_COUNT == cur_burst |=> O_ENTRY == 4'($past(O_ENTRY) + 4'h1) && O_MSG_COUNT == 4'h0)
        else $error("burst did not end on count");
    ring_wrap_a: assert property (O_GRANT_VALID && O_ENTRY == 4'hF && !I_QUEUE_PENDING[O_GRANT_QUEUE]
        |=> O_ENTRY == 4'h0)
        else $error("ring did not wrap to zero");
    empty_skip_a: assert property (O_GRANT_VALID && !I_QUEUE_PENDING[O_GRANT_QUEUE]
        |=> O_ENTRY == 4'($past(O_ENTRY) + 4'h1) && O_MSG_COUNT == 4'h0)
        else $error("empty queue not skipped");
    idle_still_a: assert property (!O_GRANT_VALID && !$past(O_GRANT_VALID) |-> $stable(O_ENTRY))
        else $error("ring moved while idle");

    // ring progress
    ring_wrap_burst_a: assert property (O_GRANT_VALID && O_ENTRY == 4'hF && I_DESC_DONE &&
        I_QUEUE_PENDING[O_GRANT_QUEUE] && O_MSG_COUNT == cur_burst |=> O_ENTRY == 4'h0)
        else $error("ring did not wrap after burst");
    entry_step_a: assert property (O_ENTRY != $past(O_ENTRY) |-> O_ENTRY == 4'($past(O_ENTRY) + 4'h1))
        else $error("ring stepped by more than one");
    count_clear_a: assert property (O_ENTRY != $past(O_ENTRY) |-> O_MSG_COUNT == 4'h0)
        else $error("count kept across entries");
    skip_no_count_a: assert property (O_GRANT_VALID && !I_QUEUE_PENDING[O_GRANT_QUEUE] && I_DESC_DONE
        |=> O_MSG_COUNT == 4'h0)
        else $error("message counted from empty queue");
    done_ignored_a: assert property (!O_GRANT_VALID |=> O_MSG_COUNT == 4'h0)
        else $error("message counted while idle");
    grant_follows_a: assert property (O_GRANT_VALID == $past(enable))
        else $error("grant valid does not follow enable");

    // entries outside the middle of the ring
    entry_zero_map_a: assert property ($stable(map) && cur_entry == 4'h0 |->
        cur_queue == map.zero[3:0] && cur_burst == map.zero[7:4])
        else $error("entry zero fields wrong");
    entry_one_map_a: assert property ($stable(map) && cur_entry == 4'h1 |->
        cur_queue == map.zero[11:8] && cur_burst == map.zero[15:12])
        else $error("entry one fields wrong");
    entry_two_map_a: assert property ($stable(map) && cur_entry == 4'h2 |->
        cur_queue == map.zero[19:16] && cur_burst == map.zero[23:20])
        else $error("entry two fields wrong");
    entry_three_map_a: assert property ($stable(map) && cur_entry == 4'h3 |->
        cur_queue == map.zero[27:24] && cur_burst == map.zero[31:28])
        else $error("entry three fields wrong");
    entry_four_map_a: assert property ($stable(map) && cur_entry == 4'h4 |->
        cur_queue == map.one[3:0] && cur_burst == map.one[7:4])
        else $error("entry four fields wrong");
    entry_fifteen_map_a: assert property ($stable(map) && cur_entry == 4'hF |->
        cur_queue == map.three[27:24] && cur_burst == map.three[31:28])
        else $error("entry fifteen fields wrong");

    // register port
    read_idle_a: assert property (!I_RD |=> O_RDATA == '0)
        else $error("read data outside read cycle");
    read_map_zero_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_MAP_ZERO |=>
        O_RDATA == $past(map.zero))
        else $error("map word zero read wrong");
    read_map_one_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_MAP_ONE |=>
        O_RDATA == $past(map.one))
        else $error("map word one read wrong");
    read_map_two_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_MAP_TWO |=>
        O_RDATA == $past(map.two))
        else $error("map word two read wrong");
    read_map_three_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_MAP_THREE |=>
        O_RDATA == $past(map.three))
        else $error("map word three read wrong");
    write_map_zero_a: assert property (I_WR && I_ADDR == tws_pkg::OFS_MAP_ZERO |=>
        map.zero == $past(I_WDATA))
        else $error("map word zero write lost");
    write_map_one_a: assert property (I_WR && I_ADDR == tws_pkg::OFS_MAP_ONE |=>
        map.one == $past(I_WDATA))
        else $error("map word one write lost");
    write_map_two_a: assert property (I_WR && I_ADDR == tws_pkg::OFS_MAP_TWO |=>
        map.two == $past(I_WDATA))
        else $error("map word two write lost");
    write_map_three_a: assert property (I_WR && I_ADDR == tws_pkg::OFS_MAP_THREE |=>
        map.three == $past(I_WDATA))
        else $error("map word three write lost");
    ctrl_read_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_CTRL |=>
        O_RDATA == {31'h00000000, $past(enable)})
        else $error("control read wrong");
    status_read_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_STATUS |=>
        O_RDATA[tws_pkg::STAT_ENTRY_LSB +: 4] == $past(O_ENTRY))
        else $error("status entry field wrong");
    status_queue_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_STATUS |=>
        O_RDATA[tws_pkg::STAT_QUEUE_LSB +: 4] == $past(O_GRANT_QUEUE))
        else $error("status queue field wrong");
    status_count_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_STATUS |=>
        O_RDATA[tws_pkg::STAT_COUNT_LSB +: 4] == $past(O_MSG_COUNT))
        else $error("status count field wrong");
    status_busy_a: assert property (I_RD && I_ADDR == tws_pkg::OFS_STATUS |=>
        O_RDATA[tws_pkg::STAT_BUSY_BIT] == $past(O_GRANT_VALID))
        else $error("status busy bit wrong");
    write_refused_a: assert property (I_WR && I_ADDR == tws_pkg::OFS_STATUS |=> $stable(map) && $stable(enable))
        else $error("status write changed state");
    unmapped_read_a: assert property (I_RD && I_ADDR > tws_pkg::OFS_STATUS |=> O_RDATA == '0)
        else $error("unmapped read not zero");

    wrap_seen_c: cover property (O_ENTRY == 4'hF ##1 O_ENTRY == 4'h0);
    long_burst_c: cover property (O_GRANT_VALID && O_MSG_COUNT == 4'hF && I_DESC_DONE);
    skip_seen_c: cover property (O_GRANT_VALID && !I_QUEUE_PENDING[O_GRANT_QUEUE]);
    mid_ring_c: cover property (O_ENTRY == 4'h9 && I_DESC_DONE && O_MSG_COUNT == 4'h3);
    burst_wrap_c: cover property (O_ENTRY == 4'hF && I_DESC_DONE ##1 O_ENTRY == 4'h0);

endmodule : tws_scheduler

// File: verilog/tws_pkg.sv
// Purpose: shared constants and types for the weighted round-robin queue scheduler
// Assumes: 32-bit register port, 16 transmit queues, 16-entry ring
// Notes: each map word holds four entries of one byte, queue select low nibble

package tws_pkg;

    // register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_MAP_ZERO = 8'h00;
    localparam logic [7:0] OFS_MAP_ONE = 8'h04;
    localparam logic [7:0] OFS_MAP_TWO = 8'h08;
    localparam logic [7:0] OFS_MAP_THREE = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // reset values: entry n points at queue n, one message each
    localparam logic [31:0] RST_MAP_ZERO = 32'h03020100;
    localparam logic [31:0] RST_MAP_ONE = 32'h07060504;
    localparam logic [31:0] RST_MAP_TWO = 32'h0B0A0908;
    localparam logic [31:0] RST_MAP_THREE = 32'h0F0E0D0C;
    localparam logic RST_ENABLE = 1'b0;

    // field positions of the four entries inside one map word
    localparam int unsigned FIELD_W = 4;
    localparam int unsigned LANE0_Q_LSB = 0;
    localparam int unsigned LANE0_B_LSB = 4;
    localparam int unsigned LANE1_Q_LSB = 8;
    localparam int unsigned LANE1_B_LSB = 12;
    localparam int unsigned LANE2_Q_LSB = 16;
    localparam int unsigned LANE2_B_LSB = 20;
    localparam int unsigned LANE3_Q_LSB = 24;
    localparam int unsigned LANE3_B_LSB = 28;

    // control and status fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned STAT_ENTRY_LSB = 0;
    localparam int unsigned STAT_COUNT_LSB = 4;
    localparam int unsigned STAT_QUEUE_LSB = 8;
    localparam int unsigned STAT_BURST_LSB = 12;
    localparam int unsigned STAT_BUSY_BIT = 16;

    // one ring entry as decoded
    typedef struct packed {
        logic [3:0] burst;
        logic [3:0] queue;
    } tws_entry_s;

    // the four map words
    typedef struct packed {
        logic [31:0] three;
        logic [31:0] two;
        logic [31:0] one;
        logic [31:0] zero;
    } tws_map_s;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SERVE = 1'b1
    } tws_state_e;

    // pick one entry out of a map word
    function automatic tws_entry_s lane_entry(input logic [31:0] word, input int unsigned q_lsb,
                                              input int unsigned b_lsb);
        tws_entry_s ent;
        ent.queue = word[q_lsb +: FIELD_W];
        ent.burst = word[b_lsb +: FIELD_W];
        return ent;
    endfunction : lane_entry

    // ring successor, fifteen wraps to zero
    function automatic logic [3:0] ring_next(input logic [3:0] entry);
        return 4'(entry + 4'h1);
    endfunction : ring_next

endpackage : tws_pkg

// File: verilog/tws_entry_decode.sv
// Purpose: selects the queue and burst fields of one ring entry
// Assumes: map words laid out one byte per entry
// Notes: purely combinational

module tws_entry_decode (
    // map contents
    input wire tws_pkg::tws_map_s i_map,
    // entry index
    input wire logic [3:0] i_entry,
    // decoded entry
    output tws_pkg::tws_entry_s o_entry
);

    always_comb begin
        case (i_entry)
            4'h0: o_entry = tws_pkg::lane_entry(i_map.zero, tws_pkg::LANE0_Q_LSB, tws_pkg::LANE0_B_LSB);
            4'h1: o_entry = tws_pkg::lane_entry(i_map.zero, tws_pkg::LANE1_Q_LSB, tws_pkg::LANE1_B_LSB);
            4'h2: o_entry = tws_pkg::lane_entry(i_map.zero, tws_pkg::LANE2_Q_LSB, tws_pkg::LANE2_B_LSB);
            4'h3: o_entry = tws_pkg::lane_entry(i_map.zero, tws_pkg::LANE3_Q_LSB, tws_pkg::LANE3_B_LSB);
            4'h4: o_entry = tws_pkg::lane_entry(i_map.one, tws_pkg::LANE0_Q_LSB, tws_pkg::LANE0_B_LSB);
            4'h5: o_entry = tws_pkg::lane_entry(i_map.one, tws_pkg::LANE1_Q_LSB, tws_pkg::LANE1_B_LSB);
            4'h6: o_entry = tws_pkg::lane_entry(i_map.one, tws_pkg::LANE2_Q_LSB, tws_pkg::LANE2_B_LSB);
            4'h7: o_entry = tws_pkg::lane_entry(i_map.one, tws_pkg::LANE3_Q_LSB, tws_pkg::LANE3_B_LSB);
            4'h8: o_entry = tws_pkg::lane_entry(i_map.two, tws_pkg::LANE0_Q_LSB, tws_pkg::LANE0_B_LSB);
            4'h9: o_entry = tws_pkg::lane_entry(i_map.two, tws_pkg::LANE1_Q_LSB, tws_pkg::LANE1_B_LSB);
            4'hA: o_entry = tws_pkg::lane_entry(i_map.two, tws_pkg::LANE2_Q_LSB, tws_pkg::LANE2_B_LSB);
            4'hB: o_entry = tws_pkg::lane_entry(i_map.two, tws_pkg::LANE3_Q_LSB, tws_pkg::LANE3_B_LSB);
            4'hC: o_entry = tws_pkg::lane_entry(i_map.three, tws_pkg::LANE0_Q_LSB, tws_pkg::LANE0_B_LSB);
            4'hD: o_entry = tws_pkg::lane_entry(i_map.three, tws_pkg::LANE1_Q_LSB, tws_pkg::LANE1_B_LSB);
            4'hE: o_entry = tws_pkg::lane_entry(i_map.three, tws_pkg::LANE2_Q_LSB, tws_pkg::LANE2_B_LSB);
            4'hF: o_entry = tws_pkg::lane_entry(i_map.three, tws_pkg::LANE3_Q_LSB, tws_pkg::LANE3_B_LSB);
            default: o_entry = '0;
        endcase
    end

endmodule : tws_entry_decode

// File: dv/tws_queue_model.sv
// Purpose: transmit queue side model feeding the scheduler
// Assumes: one descriptor taken per cycle while granted and pending
// Notes: slow mode takes a descriptor only every other cycle

module tws_queue_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bench control
    input wire logic [15:0] i_fill,
    input wire logic i_go,
    input wire logic i_slow,
    // scheduler side
    input wire logic i_grant_valid,
    input wire logic [3:0] i_grant_queue,
    output logic [15:0] o_pending,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ns;

    logic phase;

    // pacing for slow mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end

    // queues hold descriptors while their fill bit is set
    assign o_pending = i_fill;
    assign o_done = i_go && i_grant_valid && i_fill[i_grant_queue] && (!i_slow || phase);

endmodule : tws_queue_model

// File: dv/tws_scheduler_test.sv
// Purpose: self-checking bench for the round-robin queue scheduler
// Assumes: register port with read data one cycle after the strobe
// Notes: ring walked with full, sparse and slow queue sides

module tws_scheduler_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, wr, rd, done, go, slow, gvalid;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] pend, fill;
    logic [3:0] gq, entry, mcount;
    logic [31:0] map [4];
    int n_mismatch = 0;
    int compares = 0;

    tws_scheduler i_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_QUEUE_PENDING(pend), .I_DESC_DONE(done), .O_GRANT_VALID(gvalid),
        .O_GRANT_QUEUE(gq), .O_ENTRY(entry), .O_MSG_COUNT(mcount));

    tws_queue_model i_queues (.i_clk(clk), .i_rst(rst), .i_fill(fill), .i_go(go), .i_slow(slow),
        .i_grant_valid(gvalid), .i_grant_queue(gq), .o_pending(pend), .o_done(done));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic check4(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check4

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check32(rdata, exp);
    endtask : read_check

    // burst field chosen per entry, two entries at the top value
    function automatic logic [3:0] bval(input int e);
        return (e == 5 || e == 12) ? 4'hF : 4'(e % 3);
    endfunction : bval

    task automatic restart();
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask : restart

    // program all entries, then enable and follow the ring once round plus the wrap
    task automatic run_ring(input logic [15:0] f, input logic sl);
        int cnt;
        logic [3:0] q;
        restart();
        fill <= f;
        slow <= sl;
        go <= 1'b0;
        for (int e = 0; e < 16; e++) begin
            map[e / 4][(e % 4) * 8 +: 8] = {bval(e), 4'(15 - e)};
        end
        for (int w = 0; w < 4; w++) begin
            reg_write(8'(w * 4), map[w]);
            read_check(8'(w * 4), map[w]);
        end
        reg_write(tws_pkg::OFS_CTRL, 32'h00000001);
        read_check(tws_pkg::OFS_CTRL, 32'h00000001);
        cnt = 0;
        while (gvalid !== 1'b1 && cnt < 20) begin
            @(negedge clk);
            cnt++;
        end
        if (gvalid !== 1'b1) begin
            n_mismatch++;
            $display("timeout at %0t waiting on grant", $time);
            conclude();
        end
        @(posedge clk);
        go <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 17; i++) begin
            q = 4'(15 - (i % 16));
            check4(entry, 4'(i % 16));
            check4(gq, q);
            check4(mcount, 4'h0);
            cnt = 0;
            while (entry === 4'(i % 16) && cnt < 80) begin
                @(negedge clk);
                cnt++;
                if (!sl && entry === 4'(i % 16)) begin
                    check4(mcount, 4'(cnt));
                end
            end
            if (cnt >= 80) begin
                n_mismatch++;
                $display("timeout at %0t waiting on entry %0d", $time, i);
                conclude();
            end
            if (sl) begin
                cnt = (cnt + 1) / 2;
            end
            check32(32'(cnt), f[q] ? 32'(bval(i % 16)) + 32'h1 : 32'h1);
        end
    endtask : run_ring

    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        fill = 16'hFFFF;
        go = 1'b0;
        slow = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        read_check(tws_pkg::OFS_MAP_ZERO, tws_pkg::RST_MAP_ZERO);
        read_check(tws_pkg::OFS_MAP_ONE, tws_pkg::RST_MAP_ONE);
        read_check(tws_pkg::OFS_MAP_TWO, tws_pkg::RST_MAP_TWO);
        read_check(tws_pkg::OFS_MAP_THREE, tws_pkg::RST_MAP_THREE);
        read_check(tws_pkg::OFS_CTRL, 32'h00000000);
        reg_write(8'h20, 32'hFFFFFFFF);
        read_check(8'h20, 32'h00000000);
        reg_write(tws_pkg::OFS_STATUS, 32'hFFFFFFFF);
        read_check(tws_pkg::OFS_STATUS, 32'h00000000);
        $display("test register reset and access done");
        run_ring(16'hFFFF, 1'b0);
        $display("test full ring done");
        run_ring(16'hAAAA, 1'b0);
        $display("test skip of empty queues done");
        run_ring(16'hFFFF, 1'b1);
        $display("test slow queue side done");
        conclude();
    end

endmodule : tws_scheduler_test
